/* File: core/relay_threshold_controller.sv */
`include "relay_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module relay_threshold_controller
#(
   parameter int RELAYS = `RELAY_COUNT,
   parameter int CHANNELS = `CHAN_COUNT
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire relay_pkg::chan_sample_s chan [CHANNELS],
   input wire relay_pkg::relay_cfg_s cfg [RELAYS],
   input wire logic controlling,
   output var logic relay_drive [RELAYS],
   output var logic relay_lamp [RELAYS],
   output var relay_pkg::relay_status_e relay_status [RELAYS]
);
   import relay_pkg::*;

   // ==========================================
   // comparison helpers
   // sums are taken one bit wider so setpoint plus deadband never wraps,
   // and the lower bound is moved to the other side to avoid underflow

   function automatic logic above_band(
      input temp_t t,
      input temp_t sp,
      input temp_t db
   );
      logic [`TEMP_W:0] lim;
      lim = {1'b0, sp} + {1'b0, db};
      above_band = {1'b0, t} > lim;
   endfunction

   function automatic logic below_band(
      input temp_t t,
      input temp_t sp,
      input temp_t db
   );
      logic [`TEMP_W:0] lhs;
      lhs = {1'b0, t} + {1'b0, db};
      below_band = lhs < {1'b0, sp};
   endfunction

   // between the two edges of a band the previous state holds
   function automatic logic hold_state(
      input logic state,
      input logic set,
      input logic clr
   );
      hold_state = state ? !clr : set;
   endfunction

   // only the two comparing modes keep hysteresis state
   function automatic logic is_compare_mode(
      input relay_mode_e m
   );
      is_compare_mode = m == MODE_AUTO || m == MODE_WITHIN;
   endfunction

   // fail-safe window: a lost or bad reading opens the relay, so a
   // dead sensor stops the guarded process instead of leaving it on
   function automatic logic within_drive(
      input logic v,
      input logic hi,
      input logic lo
   );
      within_drive = v && !hi && !lo;
   endfunction

   // high wins when both conditions are latched at once
   function automatic relay_status_e auto_status(
      input logic hi,
      input logic lo
   );
      if (hi)
         auto_status = high_condition_status;
      else if (lo)
         auto_status = low_condition_status;
      else
         auto_status = STAT_CLEAR;
   endfunction

   // an assertion that is no temperature condition reports as on
   function automatic relay_status_e on_status(
      input logic on
   );
      on_status = on ? STAT_ON : STAT_CLEAR;
   endfunction

   // ==========================================
   // per-relay logic

   for (genvar r = 0; r < RELAYS; r++)
   begin : g_relay
      // ---------- source selection
      wire chan_sel_t sel = cfg[r].source;
      wire temp_t temp = chan[sel].temperature;
      // a source beyond a smaller channel count reads as an idle
      // channel, so a bad select can never latch a condition
      wire logic sel_ok = 32'(sel) < CHANNELS;
      wire logic valid = sel_ok && chan[sel].valid;
      wire logic sample = sel_ok && chan[sel].strobe;

      wire relay_mode_e mode = cfg[r].mode;
      wire temp_t hi_sp = cfg[r].high_setpoint;
      wire temp_t lo_sp = cfg[r].low_setpoint;
      wire temp_t db = cfg[r].deadband;
      wire logic hi_en = cfg[r].high_enable;
      wire logic lo_en = cfg[r].low_enable;

      // ---------- hysteresis state
      logic hi_cond_reg;
      logic hi_cond_next;
      logic lo_cond_reg;
      logic lo_cond_next;
      relay_mode_e mode_reg;

      // a mode change drops any condition latched under the old mode
      wire logic mode_changed = mode != mode_reg;
      wire logic compare_mode = is_compare_mode(mode);

      // ---------- band crossings
      // both edges are strict: a reading exactly on an edge of the
      // band changes nothing, which keeps a noisy reading from chatter
      wire logic hi_set = above_band(temp, hi_sp, db);
      wire logic hi_clr = below_band(temp, hi_sp, db);
      wire logic lo_set = below_band(temp, lo_sp, db);
      wire logic lo_clr = above_band(temp, lo_sp, db);

      wire logic hi_hold = hold_state(hi_cond_reg, hi_set, hi_clr);
      wire logic lo_hold = hold_state(lo_cond_reg, lo_set, lo_clr);

      // an invalid reading cannot prove either condition, so both drop
      wire logic hi_eval = hi_en && valid && hi_hold;
      wire logic lo_eval = lo_en && valid && lo_hold;

      // a condition may only move on a sample taken under a steady mode
      wire logic clear_cond = mode_changed || !compare_mode;

      always_comb
      begin
         hi_cond_next = hi_cond_reg;
         if (clear_cond)
            hi_cond_next = `COND_RST;
         else if (sample)
            hi_cond_next = hi_eval;
      end

      always_comb
      begin
         lo_cond_next = lo_cond_reg;
         if (clear_cond)
            lo_cond_next = `COND_RST;
         else if (sample)
            lo_cond_next = lo_eval;
      end

      always_ff @(posedge mclk)
      begin
         if (rst)
            hi_cond_reg <= `COND_RST;
         else
            hi_cond_reg <= hi_cond_next;
      end

      always_ff @(posedge mclk)
      begin
         if (rst)
            lo_cond_reg <= `COND_RST;
         else
            lo_cond_reg <= lo_cond_next;
      end

      // reset leaves the relay in manual-off so the first real mode
      // counts as a change and starts from clear hysteresis
      always_ff @(posedge mclk)
      begin
         if (rst)
            mode_reg <= MODE_MAN_OFF;
         else
            mode_reg <= mode;
      end

      // ---------- window validity
      // window needs the last sample valid; tracked per sample so a
      // stale valid flag between strobes does not open the window
      logic valid_reg;
      logic valid_next;

      always_comb
      begin
         valid_next = valid_reg;
         if (mode_changed)
            valid_next = `COND_RST;
         else if (sample)
            valid_next = valid;
      end

      always_ff @(posedge mclk)
      begin
         if (rst)
            valid_reg <= `COND_RST;
         else
            valid_reg <= valid_next;
      end

      // ---------- mode outputs
      wire logic any_cond = hi_cond_next || lo_cond_next;
      wire logic auto_out = any_cond;
      // inverse of threshold operation, gated by a valid reading
      wire logic within_out =
         within_drive(valid_next, hi_cond_next, lo_cond_next);

      logic drive_next;
      relay_status_e status_next;

      always_comb
      begin
         drive_next = `RELAY_RST;
         status_next = STAT_CLEAR;
         unique case (mode)
            MODE_AUTO:
            begin
               drive_next = auto_out;
               status_next = auto_status(hi_cond_next,
                  lo_cond_next);
            end
            MODE_WITHIN:
            begin
               drive_next = within_out;
               status_next = on_status(within_out);
            end
            MODE_MAN_ON:
            begin
               drive_next = 1'b1;
               status_next = STAT_ON;
            end
            MODE_MAN_OFF:
            begin
               drive_next = 1'b0;
               status_next = STAT_CLEAR;
            end
            MODE_CONTROL:
            begin
               // follows the regulating flag with one register of delay
               drive_next = controlling;
               status_next = on_status(controlling);
            end
            default:
            begin
               // an unused mode code keeps the relay safely clear
               drive_next = `RELAY_RST;
               status_next = STAT_CLEAR;
            end
         endcase
      end

      // ---------- output registers
      // drive and lamp share one next value and status comes from the same
      // case, so no reader can ever see them disagree
      always_ff @(posedge mclk)
      begin
         if (rst)
            relay_drive[r] <= `RELAY_RST;
         else
            relay_drive[r] <= drive_next;
      end

      // the lamp has a flop of its own so the lamp load never sits on
      // the relay driver net
      always_ff @(posedge mclk)
      begin
         if (rst)
            relay_lamp[r] <= `RELAY_RST;
         else
            relay_lamp[r] <= drive_next;
      end

      // panel, web and remote readers all tap this one register
      always_ff @(posedge mclk)
      begin
         if (rst)
            relay_status[r] <= STAT_CLEAR;
         else
            relay_status[r] <= status_next;
      end
   end

endmodule

`default_nettype wire

/* File: core/relay_regs.svh */
`ifndef RELAY_THRESHOLD_CONTROLLER_REGS_SVH
`define RELAY_THRESHOLD_CONTROLLER_REGS_SVH

// ==========================================
// sizes
`define RELAY_COUNT 2
`define CHAN_COUNT 4
`define CHAN_SEL_W 2
`define TEMP_W 24
`define MODE_W 3
`define STATUS_W 2

// ==========================================
// mode encodings
`define MODE_AUTO 3'h0
`define MODE_WITHIN 3'h1
`define MODE_MAN_ON 3'h3
`define MODE_MAN_OFF 3'h2
`define MODE_CONTROL 3'h6

// ==========================================
// status encodings
`define STAT_CLEAR 2'h0
`define STAT_HIGH 2'h1
`define STAT_LOW 2'h2
`define STAT_ON 2'h3

// ==========================================
// reset values
`define COND_RST 1'b0
`define RELAY_RST 1'b0

`endif

/* File: core/relay_pkg.sv */
`include "relay_regs.svh"

package relay_pkg;

   // ==========================================
   // types
   typedef logic [`TEMP_W-1:0] temp_t;
   typedef logic [`CHAN_SEL_W-1:0] chan_sel_t;

   typedef enum logic [`MODE_W-1:0]
   {
      MODE_AUTO = `MODE_AUTO,
      MODE_WITHIN = `MODE_WITHIN,
      MODE_MAN_OFF = `MODE_MAN_OFF,
      MODE_MAN_ON = `MODE_MAN_ON,
      MODE_CONTROL = `MODE_CONTROL
   } relay_mode_e;

   typedef enum logic [`STATUS_W-1:0]
   {
      STAT_CLEAR = `STAT_CLEAR,
      high_condition_status = `STAT_HIGH,
      low_condition_status = `STAT_LOW,
      STAT_ON = `STAT_ON
   } relay_status_e;

   // one relay's configuration, written by panel, web or remote software
   typedef struct packed
   {
      chan_sel_t source;
      relay_mode_e mode;
      temp_t high_setpoint;
      temp_t low_setpoint;
      logic high_enable;
      logic low_enable;
      temp_t deadband;
   } relay_cfg_s;

   // one channel's sample as delivered by the measurement side
   typedef struct packed
   {
      temp_t temperature;
      logic valid;
      logic strobe;
   } chan_sample_s;

endpackage

/* File: dv/relay_threshold_controller_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_chk
#(
   parameter int RELAYS = 2,
   parameter int CHANNELS = 4
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire relay_pkg::chan_sample_s chan [CHANNELS],
   input wire relay_pkg::relay_cfg_s cfg [RELAYS],
   input wire logic controlling,
   input wire logic relay_drive [RELAYS],
   input wire logic relay_lamp [RELAYS],
   input wire relay_pkg::relay_status_e relay_status [RELAYS]
);
   import relay_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ==========
   // per-relay checks
   for (genvar i = 0; i < RELAYS; i++)
   begin : g_r
      wire chan_sample_s smp = chan[cfg[i].source];
      wire [24:0] hi_up = cfg[i].high_setpoint + cfg[i].deadband;
      wire [24:0] t_up = smp.temperature + cfg[i].deadband;
      // first edge after reset counts as a mode change, strobe ignored
      sequence s_take;
         cfg[i].mode == MODE_AUTO && $stable(cfg[i].mode) && !$past(rst)
            && smp.strobe && smp.valid;
      endsequence
      a_lamp_drive:
         assert property (relay_lamp[i] == relay_drive[i])
         else $error("lamp mismatch");
      a_high_set:
         assert property (s_take ##0 cfg[i].high_enable
            && smp.temperature > hi_up |=> relay_drive[i]
            && relay_status[i] == high_condition_status)
         else $error("high missed");
      a_low_set:
         assert property (s_take ##0 cfg[i].low_enable
            && t_up < cfg[i].low_setpoint |=> relay_drive[i])
         else $error("low missed");
      a_within_bad:
         assert property (cfg[i].mode == MODE_WITHIN && $stable(cfg[i].mode)
            && smp.strobe && !smp.valid |=> !relay_drive[i])
         else $error("invalid kept");
      a_man_on:
         assert property (cfg[i].mode == MODE_MAN_ON
            |=> relay_drive[i] && relay_status[i] == STAT_ON)
         else $error("manual on");
      a_man_off:
         assert property (cfg[i].mode == MODE_MAN_OFF
            |=> !relay_drive[i] && relay_status[i] == STAT_CLEAR)
         else $error("manual off");
      a_control_follow:
         assert property (cfg[i].mode == MODE_CONTROL
            |=> relay_drive[i] == $past(controlling))
         else $error("control");
      a_reset_clear:
         assert property (disable iff (1'b0) rst
            |=> !relay_drive[i] && relay_status[i] == STAT_CLEAR)
         else $error("reset");
   end
endmodule
bind relay_threshold_controller relay_chk
   #(.RELAYS(RELAYS), .CHANNELS(CHANNELS)) u_chk (.mclk(mclk), .rst(rst),
   .chan(chan), .cfg(cfg), .controlling(controlling),
   .relay_drive(relay_drive), .relay_lamp(relay_lamp),
   .relay_status(relay_status));
`default_nettype wire

/* File: dv/chan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module chan_model
(
   input wire logic mclk,
   input wire logic go,
   input wire logic [1:0] idx,
   input wire relay_pkg::temp_t t,
   input wire logic ok,
   output var relay_pkg::chan_sample_s chan [4]
);
   import relay_pkg::*;
   // ==========
   // reading wanders between samples so a stale capture shows
   always @(posedge mclk)
      for (int k = 0; k < 4; k++)
         chan[k] <= (go && idx == k) ? {t, ok, 1'b1}
            : {~chan[k].temperature, chan[k].valid, 1'b0};
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import relay_pkg::*;
   logic mclk, rst, controlling, go, ok, e;
   logic [1:0] idx, es;
   temp_t t;
   chan_sample_s chan [4];
   relay_cfg_s cfg [2];
   logic drv [2], lamp [2];
   relay_status_e st [2];
   bit hl [2], ll [2], vl [2];
   int miscompares = 0, checked = 0, cyc = 0, seed = 82633;
   relay_mode_e modes [5] = '{MODE_AUTO, MODE_WITHIN, MODE_MAN_ON,
      MODE_MAN_OFF, MODE_CONTROL};

   chan_model far (.mclk(mclk), .go(go), .idx(idx), .t(t), .ok(ok),
      .chan(chan));
   relay_threshold_controller DUT (.mclk(mclk), .rst(rst), .chan(chan),
      .cfg(cfg), .controlling(controlling), .relay_drive(drv),
      .relay_lamp(lamp), .relay_status(st));

   // ==========
   // helpers
   function temp_t rnd(int n);
      return temp_t'({$random(seed)} % n);
   endfunction

   task cmp(logic [1:0] got, logic [1:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %0t %h %h", $time, got, exp);
      end
   endtask

   task final_report;
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // boundary-heavy reading around one setpoint of relay r
   task sample(int r, bit own);
      temp_t b, d;
      b = rnd(2) ? cfg[r].high_setpoint : cfg[r].low_setpoint;
      d = cfg[r].deadband;
      @(posedge mclk);
      go <= 1;
      idx <= (own || rnd(3)) ? cfg[r].source : chan_sel_t'(rnd(4));
      t <= b - d - 2 + rnd(2 * d + 5);
      ok <= rnd(6) != 0;
      controlling <= rnd(2) != 0;
      @(posedge mclk);
      go <= 0;
      @(posedge mclk);
      #1;
      for (int k = 0; k < 2; k++)
      begin
         b = cfg[k].high_setpoint;
         d = cfg[k].deadband;
         if (cfg[k].source == idx && cfg[k].mode inside {0, 1})
         begin
            vl[k] = ok;
            if (!ok || !cfg[k].high_enable)
               hl[k] = 0;
            else if (t > b + d || t + d < b)
               hl[k] = t > b + d;
            b = cfg[k].low_setpoint;
            if (!ok || !cfg[k].low_enable)
               ll[k] = 0;
            else if (t > b + d || t + d < b)
               ll[k] = t + d < b;
         end
         e = 0;
         case (cfg[k].mode)
            MODE_AUTO: e = hl[k] | ll[k];
            MODE_WITHIN: e = vl[k] & !hl[k] & !ll[k];
            MODE_MAN_ON: e = 1;
            MODE_CONTROL: e = controlling;
            default: e = 0;
         endcase
         es = !e ? 0 : cfg[k].mode != MODE_AUTO ? 3 : hl[k] ? 1 : 2;
         cmp(drv[k], e);
         cmp(lamp[k], e);
         cmp(st[k], es);
      end
   endtask

   task setup(int r, relay_mode_e m);
      temp_t h;
      h = 1000 + rnd(500);
      @(posedge mclk);
      cfg[r].mode <= MODE_MAN_OFF;
      @(posedge mclk);
      cfg[r] <= '{chan_sel_t'(rnd(4)), m, h, h - 100 - rnd(300),
         rnd(2) != 0, rnd(2) != 0, rnd(8)};
      hl[r] = 0;
      ll[r] = 0;
      sample(r, 1);
   endtask

   initial
   begin
      mclk = 0;
      forever
         #5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         miscompares++;
         final_report;
      end
   end

   initial
   begin
      {rst, go, ok, idx, t, controlling} = '1;
      go = 0;
      cfg[0] = '0;
      cfg[1] = '0;
      repeat (12) @(posedge mclk);
      rst <= 0;
      for (int ph = 0; ph < 40; ph++)
      begin
         setup(ph % 2, modes[ph / 2 % 5]);
         repeat (12) sample(ph % 2, 0);
      end
      final_report;
   end
endmodule
`default_nettype wire
